// File: core/msrs_server.v
/*
 * Read Input Register server for a two-slot sensor data block. Takes
 * received query bytes with an end-of-frame strobe, answers with a
 * response or exception byte stream, and keeps the sixteen data words.
 * Assumes a byte UART and silence-gap detector on the same clock.
 */
`timescale 1ns/1ns
`include "msrs_regs.vh"
module msrs_server (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Own station address
   input wire [7:0] slave_addr,
   // Received bytes and end-of-frame gap
   input wire rx_valid,
   input wire [7:0] rx_byte,
   input wire rx_end,
   // Transmit bytes
   output reg tx_valid_r,
   output reg [7:0] tx_byte_r,
   input wire tx_ready,
   output reg tx_busy_r,
   // Sensor data updates
   input wire upd_valid,
   input wire [1:0] upd_kind,
   input wire [3:0] upd_addr,
   input wire [15:0] upd_word,
   input wire [31:0] upd_float,
   input wire [7:0] upd_mode,
   input wire [3:0] upd_main_st,
   input wire [3:0] upd_sec_st,
   output reg upd_ready_r
);
   localparam ST_IDLE = 8'h01;
   localparam ST_ADDR = 8'h02;
   localparam ST_FUNC = 8'h04;
   localparam ST_THIRD = 8'h08;
   localparam ST_DHI = 8'h10;
   localparam ST_DLO = 8'h20;
   localparam ST_CRCL = 8'h40;
   localparam ST_CRCH = 8'h80;

   function [15:0] crc_step;
      input [15:0] c;
      input [7:0] d;
      integer i;
      reg [15:0] x;
      begin
         x = c ^ {8'h00, d};
         for (i = 0; i < 8; i = i + 1)
            x = x[0] ? ((x >> 1) ^ `MSRS_CRC_POLY) : (x >> 1);
         crc_step = x;
      end
   endfunction

   // Query collector
   reg [7:0] q_r [0:7];
   reg [3:0] q_cnt_r;
   reg [15:0] rx_crc_r;
   // Response sequencer
   reg [7:0] state_r;
   reg [7:0] state_nxt;
   reg exc_r;
   reg [7:0] func_r;
   reg [7:0] third_r;
   reg [3:0] ptr_r;
   reg [4:0] left_r;
   reg [15:0] tx_crc_r;
   reg settle_r;
   // Update sequencer
   reg float_pend_r;
   reg [3:0] float_addr_r;
   reg [15:0] float_lo_r;
   reg wr_en;
   reg [3:0] wr_addr;
   reg [15:0] wr_data;
   wire [15:0] rd_data;

   wire [15:0] q_start = {q_r[`MSRS_Q_START_HI], q_r[`MSRS_Q_START_LO]};
   wire [15:0] q_count = {q_r[`MSRS_Q_CNT_HI], q_r[`MSRS_Q_CNT_LO]};
   wire [16:0] q_end = {1'b0, q_start} + {1'b0, q_count};
   wire frame_ok = (q_cnt_r == `MSRS_Q_LEN) && (rx_crc_r == `MSRS_CRC_GOOD)
                   && (q_r[`MSRS_Q_ADDR] == slave_addr);
   wire func_bad = q_r[`MSRS_Q_FUNC] != `MSRS_FUNC_READ_IN;
   wire cnt_bad = (q_count == 16'h0000) ||
                  (q_count > {11'h000, `MSRS_BLOCK_REGS});
   wire range_bad = q_end > {12'h000, `MSRS_BLOCK_REGS};
   wire idle = state_r == ST_IDLE;
   wire tx_take = tx_valid_r && tx_ready;

   // Collector: bytes during a response are dropped
   always @(posedge ref_clk) begin
      if (rst) begin
         q_cnt_r <= 4'd0;
         rx_crc_r <= `MSRS_CRC_INIT;
      end else if (rx_end) begin
         q_cnt_r <= 4'd0;
         rx_crc_r <= `MSRS_CRC_INIT;
      end else if (rx_valid && idle) begin
         // Running check over all bytes ends at zero on a good frame
         rx_crc_r <= crc_step(rx_crc_r, rx_byte);
         if (q_cnt_r < `MSRS_Q_LEN)
            q_r[q_cnt_r[2:0]] <= rx_byte;
         if (q_cnt_r != `MSRS_Q_OVERLONG)
            q_cnt_r <= q_cnt_r + 4'd1;
      end
   end

   // Byte presented in each state
   reg [7:0] cur_byte;
   always @* begin
      case (state_r)
         ST_ADDR: cur_byte = slave_addr;
         ST_FUNC: cur_byte = func_r;
         ST_THIRD: cur_byte = third_r;
         ST_DHI: cur_byte = rd_data[15:8];
         ST_DLO: cur_byte = rd_data[7:0];
         ST_CRCL: cur_byte = tx_crc_r[7:0];
         ST_CRCH: cur_byte = tx_crc_r[15:8];
         default: cur_byte = 8'h00;
      endcase
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: state_nxt = ST_IDLE;
         ST_ADDR: state_nxt = ST_FUNC;
         ST_FUNC: state_nxt = ST_THIRD;
         ST_THIRD: state_nxt = exc_r ? ST_CRCL : ST_DHI;
         ST_DHI: state_nxt = ST_DLO;
         ST_DLO: state_nxt = (left_r == 5'd1) ? ST_CRCL : ST_DHI;
         ST_CRCL: state_nxt = ST_CRCH;
         ST_CRCH: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Response sequencer
   always @(posedge ref_clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         exc_r <= 1'b0;
         func_r <= 8'h00;
         third_r <= 8'h00;
         ptr_r <= 4'd0;
         left_r <= 5'd0;
         tx_crc_r <= `MSRS_CRC_INIT;
         settle_r <= 1'b0;
         tx_valid_r <= 1'b0;
         tx_byte_r <= 8'h00;
         tx_busy_r <= 1'b0;
      end else if (idle) begin
         tx_valid_r <= 1'b0;
         tx_crc_r <= `MSRS_CRC_INIT;
         // Wrong length, checksum or station: no answer at all
         if (rx_end && frame_ok) begin
            state_r <= ST_ADDR;
            tx_busy_r <= 1'b1;
            settle_r <= 1'b1;
            exc_r <= func_bad || cnt_bad || range_bad;
            func_r <= (func_bad || cnt_bad || range_bad) ?
                      (q_r[`MSRS_Q_FUNC] | `MSRS_EXC_FLAG) :
                      q_r[`MSRS_Q_FUNC];
            if (func_bad)
               third_r <= `MSRS_EXC_FUNC;
            else if (cnt_bad)
               third_r <= `MSRS_EXC_VALUE;
            else if (range_bad)
               third_r <= `MSRS_EXC_ADDR;
            else
               third_r <= {q_count[6:0], 1'b0};
            ptr_r <= q_start[3:0];
            left_r <= q_count[4:0];
         end
      end else begin
         settle_r <= 1'b0;
         if (tx_take) begin
            tx_valid_r <= 1'b0;
            // Check bytes must not fold into the check they carry
            if (state_r != ST_CRCL && state_r != ST_CRCH)
               tx_crc_r <= crc_step(tx_crc_r, tx_byte_r);
            state_r <= state_nxt;
            if (state_r == ST_DLO) begin
               // Read data lags the pointer by one cycle
               ptr_r <= ptr_r + 4'd1;
               left_r <= left_r - 5'd1;
               settle_r <= 1'b1;
            end
            if (state_r == ST_CRCH)
               tx_busy_r <= 1'b0;
         end else if (!tx_valid_r && !settle_r) begin
            tx_valid_r <= 1'b1;
            tx_byte_r <= cur_byte;
         end
      end
   end

   // Data updates; a float takes two cycles, so updates stall meanwhile
   always @* begin
      wr_en = 1'b0;
      wr_addr = upd_addr;
      wr_data = upd_word;
      if (float_pend_r) begin
         wr_en = 1'b1;
         wr_addr = float_addr_r;
         wr_data = float_lo_r;
      end else if (upd_valid) begin
         wr_en = 1'b1;
         case (upd_kind)
            `MSRS_UPD_FLOAT: wr_data = upd_float[31:16];
            `MSRS_UPD_STATUS: begin
               wr_addr = {upd_addr[3], `MSRS_IDX_STATUS};
               wr_data = {upd_mode, upd_main_st, upd_sec_st};
            end
            default: wr_data = upd_word;
         endcase
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         float_pend_r <= 1'b0;
         float_addr_r <= 4'd0;
         float_lo_r <= 16'h0000;
         upd_ready_r <= 1'b1;
      end else if (float_pend_r) begin
         float_pend_r <= 1'b0;
         upd_ready_r <= 1'b1;
      end else if (upd_valid && upd_kind == `MSRS_UPD_FLOAT) begin
         float_pend_r <= 1'b1;
         float_addr_r <= upd_addr + 4'd1;
         float_lo_r <= upd_float[15:0];
         upd_ready_r <= 1'b0;
      end
   end

   msrs_regmem #(
      .WORDS(16),
      .AW(4)
   ) u_mem (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_addr(ptr_r),
      .rd_data_r(rd_data)
   );
endmodule

// File: core/msrs_regs.vh
/*
 * Constants of the sensor register server: frame layout, function and
 * exception codes, checksum, register block geometry and status codes.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef MSRS_REGS_VH
`define MSRS_REGS_VH

// Register block geometry
`define MSRS_BLOCK_REGS     5'd16
`define MSRS_REGS_PER_SLOT  4'd8
`define MSRS_IDX_STATUS     3'd3

// Query frame: byte positions and length
`define MSRS_Q_ADDR         3'd0
`define MSRS_Q_FUNC         3'd1
`define MSRS_Q_START_HI     3'd2
`define MSRS_Q_START_LO     3'd3
`define MSRS_Q_CNT_HI       3'd4
`define MSRS_Q_CNT_LO       3'd5
`define MSRS_Q_LEN          4'd8
`define MSRS_Q_OVERLONG     4'd9

// Function and exception codes
`define MSRS_FUNC_READ_IN   8'h04
`define MSRS_EXC_FLAG       8'h80
`define MSRS_EXC_FUNC       8'h01
`define MSRS_EXC_ADDR       8'h02
`define MSRS_EXC_VALUE      8'h03

// Checksum
`define MSRS_CRC_INIT       16'hffff
`define MSRS_CRC_POLY       16'ha001
`define MSRS_CRC_GOOD       16'h0000

// Measured value status nibbles
`define MSRS_ST_VALID       4'h1
`define MSRS_ST_ABSENT      4'h4

// Update kinds
`define MSRS_UPD_WORD       2'd0
`define MSRS_UPD_FLOAT      2'd1
`define MSRS_UPD_STATUS     2'd2

`endif

// File: core/msrs_regmem.v
/*
 * Sixteen-word sensor data store with one write port and a registered
 * read port. Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/1ns
module msrs_regmem #(
   parameter WORDS = 16,
   parameter AW = 4
) (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Write port
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [15:0] wr_data,
   // Read port, data one cycle after address
   input wire [AW-1:0] rd_addr,
   output reg [15:0] rd_data_r
);
   reg [15:0] mem [0:WORDS-1];
   integer k;

   always @(posedge ref_clk) begin
      if (rst) begin
         for (k = 0; k < WORDS; k = k + 1)
            mem[k] <= 16'h0000;
         rd_data_r <= 16'h0000;
      end else begin
         if (wr_en)
            mem[wr_addr] <= wr_data;
         rd_data_r <= mem[rd_addr];
      end
   end
endmodule

// File: sim/msrs_monitor.sv
/* Checker for the server's link and update ports.
   Assumes one clock and synchronous active-high reset. */
`timescale 1ns/1ns
module msrs_monitor (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Link side
   input wire [7:0] slave_addr,
   input wire rx_end,
   input wire tx_valid_r,
   input wire [7:0] tx_byte_r,
   input wire tx_ready,
   input wire tx_busy_r,
   // Update side
   input wire upd_valid,
   input wire [1:0] upd_kind,
   input wire upd_ready_r
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   reg [5:0] take_r;
   wire take = tx_valid_r && tx_ready;
   // Bytes taken so far in this response
   always @(posedge ref_clk)
      take_r <= (rst || !tx_busy_r) ? 6'h00 : take_r + {5'h00, take};
   a_busy_after_end: assert property (
      $rose(tx_busy_r) |-> $past(rx_end))
      else $error("response began without frame end");
   // Busy rises two edges before the first byte is offered
   a_addr_first: assert property (
      $rose(tx_busy_r) |-> ##2 tx_valid_r && tx_byte_r == slave_addr)
      else $error("first byte is not own address");
   a_func_echo: assert property (
      tx_valid_r && take_r == 6'h01 |-> tx_byte_r == 8'h04 || tx_byte_r[7])
      else $error("second byte is not function echo");
   a_byte_hold: assert property (
      tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_byte_r))
      else $error("byte changed before taken");
   a_take_gap: assert property (take |=> !tx_valid_r)
      else $error("no gap after take");
   a_next_soon: assert property (
      take |-> ##[2:3] (tx_valid_r || !tx_busy_r))
      else $error("next byte late");
   a_valid_busy: assert property (tx_valid_r |-> tx_busy_r)
      else $error("byte offered outside response");
   a_float_gap: assert property (
      upd_valid && upd_ready_r && upd_kind == 2'h1
      |=> !upd_ready_r ##1 upd_ready_r)
      else $error("float update gap wrong");
   a_word_ready: assert property (
      upd_valid && upd_ready_r && upd_kind != 2'h1 |=> upd_ready_r)
      else $error("word update stalled");
   c_resp: cover property ($rose(tx_busy_r));
   c_stall: cover property (tx_valid_r && !tx_ready);
   c_float: cover property (upd_valid && upd_ready_r && upd_kind == 2'h1);
endmodule
bind msrs_server msrs_monitor mon (.ref_clk(ref_clk), .rst(rst),
   .slave_addr(slave_addr), .rx_end(rx_end), .tx_valid_r(tx_valid_r),
   .tx_byte_r(tx_byte_r), .tx_ready(tx_ready), .tx_busy_r(tx_busy_r),
   .upd_valid(upd_valid), .upd_kind(upd_kind), .upd_ready_r(upd_ready_r));

// File: sim/msrs_master.sv
/* Link master model: sends queries, collects response bytes.
   Assumes the server's byte ports on the same clock. */
`timescale 1ns/1ns
module msrs_master (
   // Clock
   input wire ref_clk,
   // Query bytes
   output reg rx_valid,
   output reg [7:0] rx_byte,
   output reg rx_end,
   // Response bytes
   input wire tx_valid_r,
   input wire [7:0] tx_byte_r,
   output reg tx_ready
);
   bit slow = 1'h0;
   logic [7:0] resp[$];
   initial begin
      rx_valid = 1'h0;
      rx_byte = 8'h00;
      rx_end = 1'h0;
      tx_ready = 1'h1;
   end
   function automatic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction
   // Address, function, zero-based start, count
   task automatic send(input [7:0] a, f, input [15:0] st, n, input bit bad);
      logic [7:0] q[$];
      logic [15:0] c;
      q = '{a, f, st[15:8], st[7:0], n[15:8], n[7:0]};
      c = crc16(q) ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      resp.delete();
      foreach (q[i]) begin
         @(negedge ref_clk);
         rx_valid <= 1'h1;
         rx_byte <= q[i];
      end
      @(negedge ref_clk);
      rx_valid <= 1'h0;
      // Released line must not keep the last byte
      rx_byte <= ~rx_byte;
      rx_end <= 1'h1;
      @(negedge ref_clk);
      rx_end <= 1'h0;
   endtask
   always @(posedge ref_clk)
      if (tx_valid_r && tx_ready)
         resp.push_back(tx_byte_r);
   always @(negedge ref_clk)
      tx_ready <= slow ? ~tx_ready : 1'h1;
endmodule

// File: sim/testbench.sv
/* Bench: reset read, query table, ignored frames, stalled read.
   Assumes msrs_server, msrs_master and the bound checker. */
`timescale 1ns/1ns
module testbench;
   reg ref_clk = 1'h0;
   reg rst = 1'h1;
   reg upd_valid = 1'h0;
   reg [1:0] upd_kind = 2'h0;
   reg [3:0] upd_addr = 4'h0;
   reg [31:0] v = 32'h00000000;
   wire rx_valid, rx_end, tx_valid_r, tx_ready, tx_busy_r, upd_ready_r;
   wire [7:0] rx_byte, tx_byte_r;
   int n_fail = 0, checked = 0, cyc = 0;
   logic [15:0] mem[16] = '{default: 16'h0000};
   logic [7:0] exp[$];
   // Function, start, count, expected exception code
   logic [47:0] rows[8] = '{{8'h04, 16'h0000, 16'h0010, 8'h00},
      {8'h04, 16'h0008, 16'h0008, 8'h00}, {8'h04, 16'h000f, 16'h0001, 8'h00},
      {8'h04, 16'h0000, 16'h0000, 8'h03}, {8'h04, 16'h0000, 16'h0011, 8'h03},
      {8'h04, 16'h0009, 16'h0008, 8'h02}, {8'h03, 16'h0000, 16'h0001, 8'h01},
      {8'h03, 16'h0000, 16'h0000, 8'h01}};
   msrs_server dut (.ref_clk(ref_clk), .rst(rst), .slave_addr(8'h01),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
      .tx_valid_r(tx_valid_r), .tx_byte_r(tx_byte_r), .tx_ready(tx_ready),
      .tx_busy_r(tx_busy_r), .upd_valid(upd_valid), .upd_kind(upd_kind),
      .upd_addr(upd_addr), .upd_word(v[15:0]), .upd_float(v),
      .upd_mode(v[15:8]), .upd_main_st(v[7:4]), .upd_sec_st(v[3:0]),
      .upd_ready_r(upd_ready_r));
   msrs_master m (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_end(rx_end), .tx_valid_r(tx_valid_r), .tx_byte_r(tx_byte_r),
      .tx_ready(tx_ready));
   initial forever #20 ref_clk = ~ref_clk;
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk_bit(input logic got, want);
      checked++;
      if (got !== want) begin
         n_fail++;
         $display("mismatch at %0t: flag %b", $time, got);
      end
   endtask
   task automatic chk_resp;
      bit bad;
      checked++;
      bad = m.resp.size() != exp.size();
      foreach (exp[i])
         if (!bad && m.resp[i] !== exp[i])
            bad = 1'h1;
      if (bad) begin
         n_fail++;
         $display("mismatch at %0t: response %p", $time, m.resp);
      end
   endtask
   task automatic upd(input [1:0] k, input [3:0] a, input [31:0] d);
      @(negedge ref_clk);
      upd_valid = 1'h1;
      upd_kind = k;
      upd_addr = a;
      v = d;
      @(negedge ref_clk);
      upd_valid = 1'h0;
      @(negedge ref_clk);
   endtask
   task automatic expect_resp(input [47:0] r);
      logic [15:0] c;
      exp = '{8'h01, r[47:40] | (r[7:0] != 8'h00 ? 8'h80 : 8'h00)};
      if (r[7:0] != 8'h00)
         exp.push_back(r[7:0]);
      else begin
         exp.push_back(8'(r[23:8] * 2));
         for (int i = 0; i < r[23:8]; i++) begin
            c = mem[4'(r[39:24] + i)];
            exp.push_back(c[15:8]);
            exp.push_back(c[7:0]);
         end
      end
      c = m.crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
   endtask
   task automatic query(input [7:0] a, input [47:0] r, input bit bad);
      int k;
      m.send(a, r[47:40], r[39:24], r[23:8], bad);
      @(negedge ref_clk);
      for (k = 0; k < 2000 && tx_busy_r !== 1'h0; k++)
         @(negedge ref_clk);
   endtask
   initial begin
      repeat (4) @(negedge ref_clk);
      rst = 1'h0;
      chk_bit(tx_busy_r, 1'h0);
      chk_bit(upd_ready_r, 1'h1);
      expect_resp(rows[0]);
      query(8'h01, rows[0], 1'h0);
      chk_resp();
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         mem[i] = {4'(i), 8'ha5, 4'(~i)};
         upd(2'h0, 4'(i), {16'h0000, mem[i]});
      end
      upd(2'h1, 4'hc, 32'h429e46c2);
      mem[12] = 16'h429e;
      mem[13] = 16'h46c2;
      upd(2'h2, 4'h8, 32'h00000014);
      mem[11] = 16'h0014;
      foreach (rows[i]) begin
         expect_resp(rows[i]);
         query(8'h01, rows[i], 1'h0);
         chk_resp();
      end
      $display("test table done");
      exp.delete();
      query(8'h01, rows[0], 1'h1);
      chk_resp();
      query(8'h02, rows[0], 1'h0);
      chk_resp();
      $display("test ignored frames done");
      // Float at the top word wraps its low half to word 0
      upd(2'h1, 4'hf, 32'hdeadbeef);
      mem[15] = 16'hdead;
      mem[0] = 16'hbeef;
      m.slow = 1'h1;
      expect_resp(rows[0]);
      query(8'h01, rows[0], 1'h0);
      chk_resp();
      m.slow = 1'h0;
      $display("test stalled read done");
      print_verdict();
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
endmodule
